// *** stp_pkg.sv ***
package stp_pkg;
  // ****************************************************************
  // word format and link timing
  // ****************************************************************
  localparam int WORD_W = 13;
  localparam int FIFO_DEPTH = 16;
  localparam int SAMPLE_RATE_HZ = 8000;
  localparam int LINK_BIT_HZ = 104000;
  localparam int CLK_HZ = 250_000_000;
  // half a link clock period, rounded down so the link never runs slow
  localparam int HALF_CYC = CLK_HZ / (2 * LINK_BIT_HZ);
  // least reset pulse, rounded up
  localparam int RST_MIN_MS = 4;
  localparam int RST_CYC = (CLK_HZ / 1000) * RST_MIN_MS;
  // mode must settle for more than this before reset
  localparam int SETTLE_S = 1;
  localparam int SETTLE_CYC = CLK_HZ * SETTLE_S + 1;

  // ****************************************************************
  // modes selected by the two select lines
  // ****************************************************************
  typedef enum logic [1:0] {
    STP_NORMAL,
    STP_DOWNLINK,
    STP_UPLINK,
    STP_ACOUSTIC
  } stp_mode_t;

  function automatic stp_mode_t stp_decode(input logic [1:0] sel);
    case (sel)
      2'h0: stp_decode = STP_NORMAL;
      2'h1: stp_decode = STP_DOWNLINK;
      2'h2: stp_decode = STP_UPLINK;
      default: stp_decode = STP_ACOUSTIC;
    endcase
  endfunction : stp_decode
endpackage : stp_pkg

// *** stp_if.sv ***
`timescale 1ns/10ps
interface stp_if;
  logic link_clk;
  logic mob_data;
  logic tst_data;
  logic [1:0] sel;
  logic test_nrst;

  modport mobile (
    output link_clk,
    output mob_data,
    input tst_data,
    input sel,
    input test_nrst
  );

  modport tester (
    input link_clk,
    input mob_data,
    output tst_data,
    output sel,
    output test_nrst
  );
endinterface : stp_if

// *** stp_fifo.sv ***
`timescale 1ns/10ps
module stp_fifo #(
  parameter int W = 13,
  parameter int DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push & ~pop) begin
      count_next = count_reg + CW'(1);
    end else if (pop & ~push) begin
      count_next = count_reg - CW'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_next;
      in_ready_o <= (count_next != CW'(DEPTH));
      out_valid_o <= (count_next != '0);
    end
  end
endmodule : stp_fifo

// *** stp_mobile.sv ***
// What the document requires
// R01: 13-bit samples, 8000/s, 104 kbit/s serial
// R02: one data line per direction
// R03: mobile makes clock, pulses only when needed
// R04: tester drives selects and reset
// R05: reset low resets transcoder and converters
// R06: reset active low, held 4 ms
// R07: 13-bit two's complement, MSB first
// R08: sample on rise, change on fall
// R09: clock idles high between transfers
// R10: select lines decode four modes
// R11: mode set by lines or air message; this block takes the mode from the select lines only
// R12: tester waits over one second, then resets
// R13: after reset release, clock as data needed
// R14: uplink starts at block frame after release
// R15: downlink starts at first completed block frame
// R16: test modes restart transcoders at reset end
// R17: clock held high in reset and normal
`timescale 1ns/10ps
module stp_mobile #(
  parameter int WORD_W = stp_pkg::WORD_W,
  parameter int FIFO_DEPTH = stp_pkg::FIFO_DEPTH,
  parameter int HALF_CYC = stp_pkg::HALF_CYC
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  stp_if.mobile link,
  input wire logic [WORD_W-1:0] dl_data_i,
  input wire logic dl_valid_i,
  output logic dl_ready_o,
  output logic [WORD_W-1:0] ul_data_o,
  output logic ul_valid_o,
  input wire logic ul_ready_i,
  input wire logic frame_i,
  output stp_pkg::stp_mode_t mode_o,
  output logic codec_rst_o,
  output logic codec_restart_o
);
  localparam int HW = $clog2(HALF_CYC + 1);
  localparam int BW = $clog2(WORD_W + 1);

  typedef enum {ST_HALT, ST_WAIT_FRAME, ST_READY, ST_LOW, ST_HIGH} stp_state_t;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] sel_s1_reg;
  logic [1:0] sel_s2_reg;
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rst_prev_reg;
  logic din_s1_reg;
  logic din_s2_reg;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_s1_reg <= 2'h0;
      sel_s2_reg <= 2'h0;
      // idle level of the pin, so leaving reset is no false release
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= 1'b1;
      rst_prev_reg <= 1'b1;
      din_s1_reg <= 1'b0;
      din_s2_reg <= 1'b0;
    end else begin
      sel_s1_reg <= link.sel; // R04
      sel_s2_reg <= sel_s1_reg;
      rst_s1_reg <= link.test_nrst; // R04
      rst_s2_reg <= rst_s1_reg;
      rst_prev_reg <= rst_s2_reg;
      din_s1_reg <= link.tst_data; // R02
      din_s2_reg <= din_s1_reg;
    end
  end

  // ****************************************************************
  // mode decode and transcoder reset
  // ****************************************************************
  logic release_evt;
  logic test_mode;

  assign release_evt = rst_s2_reg & ~rst_prev_reg;
  assign test_mode = (mode_o != stp_pkg::STP_NORMAL);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_o <= stp_pkg::STP_NORMAL;
      codec_rst_o <= 1'b1;
      codec_restart_o <= 1'b0;
    end else begin
      mode_o <= stp_pkg::stp_decode(sel_s2_reg); // R10 R11
      codec_rst_o <= ~rst_s2_reg; // R05 R06
      codec_restart_o <= release_evt & test_mode; // R16
    end
  end

  // ****************************************************************
  // downlink sample buffer
  // ****************************************************************
  logic [WORD_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;

  stp_fifo #(
    .W(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .in_data_i(dl_data_i),
    .in_valid_i(dl_valid_i),
    .in_ready_o(dl_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  // ****************************************************************
  // link sequencer and clock divider
  // ****************************************************************
  stp_state_t state_reg;
  logic [HW-1:0] half_reg;
  logic [BW-1:0] bit_reg;
  logic [WORD_W-1:0] tx_sh_reg;
  logic [WORD_W-1:0] rx_sh_reg;
  logic link_clk_reg;
  logic dout_reg;
  logic ul_valid_reg;
  logic need_tx;
  logic need_rx;
  logic go;
  logic half_done;
  logic halt;
  logic [WORD_W-1:0] tx_word;

  assign need_tx = (mode_o == stp_pkg::STP_DOWNLINK) || (mode_o == stp_pkg::STP_ACOUSTIC);
  assign need_rx = (mode_o == stp_pkg::STP_UPLINK) || (mode_o == stp_pkg::STP_ACOUSTIC);
  // a word starts only when a sending mode has a buffered word and a receiving mode has room for one
  assign go = (~need_tx | fifo_valid) & (~need_rx | ~ul_valid_reg); // R03 R13
  assign fifo_pop = (state_reg == ST_READY) & go & need_tx & ~halt;
  assign tx_word = need_tx ? fifo_data : '0;
  assign half_done = (half_reg == HW'(HALF_CYC - 1));
  assign halt = ~rst_s2_reg | ~test_mode; // R17

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_HALT;
      half_reg <= '0;
      bit_reg <= '0;
      tx_sh_reg <= '0;
      rx_sh_reg <= '0;
      link_clk_reg <= 1'b1;
      dout_reg <= 1'b0;
    end else if (halt) begin
      state_reg <= ST_HALT;
      half_reg <= '0;
      link_clk_reg <= 1'b1; // R09 R17
      dout_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_HALT: begin
          if (release_evt) begin
            state_reg <= ST_WAIT_FRAME; // R13
          end
        end
        ST_WAIT_FRAME: begin
          if (frame_i) begin
            state_reg <= ST_READY; // R14 R15
          end
        end
        ST_READY: begin
          link_clk_reg <= 1'b1; // R09
          if (go) begin
            state_reg <= ST_LOW;
            half_reg <= '0;
            bit_reg <= '0;
            link_clk_reg <= 1'b0;
            dout_reg <= tx_word[WORD_W-1]; // R07 R08 R14 R15
            tx_sh_reg <= {tx_word[WORD_W-2:0], 1'b0};
          end
        end
        ST_LOW: begin
          half_reg <= half_reg + HW'(1);
          if (half_done) begin
            state_reg <= ST_HIGH;
            half_reg <= '0;
            link_clk_reg <= 1'b1;
            rx_sh_reg <= {rx_sh_reg[WORD_W-2:0], din_s2_reg}; // R08
          end
        end
        ST_HIGH: begin
          half_reg <= half_reg + HW'(1);
          if (half_done) begin
            half_reg <= '0;
            if (bit_reg == BW'(WORD_W - 1)) begin
              state_reg <= ST_READY; // R01 R07
            end else begin
              state_reg <= ST_LOW;
              bit_reg <= bit_reg + BW'(1);
              link_clk_reg <= 1'b0;
              dout_reg <= tx_sh_reg[WORD_W-1]; // R08
              tx_sh_reg <= {tx_sh_reg[WORD_W-2:0], 1'b0};
            end
          end
        end
        default: begin
          state_reg <= ST_HALT;
        end
      endcase
    end
  end

  // ****************************************************************
  // uplink sample hand-off
  // ****************************************************************
  logic word_end;

  assign word_end = (state_reg == ST_HIGH) & half_done & (bit_reg == BW'(WORD_W - 1)) & ~halt;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ul_valid_reg <= 1'b0;
      ul_data_o <= '0;
    end else if (word_end & need_rx) begin
      ul_valid_reg <= 1'b1;
      ul_data_o <= rx_sh_reg;
    end else if (ul_ready_i) begin
      ul_valid_reg <= 1'b0;
    end
  end

  assign ul_valid_o = ul_valid_reg;
  assign link.link_clk = link_clk_reg; // R03
  assign link.mob_data = dout_reg; // R02
endmodule : stp_mobile

// *** stp_tester.sv ***
`timescale 1ns/10ps
module stp_tester #(
  parameter int WORD_W = stp_pkg::WORD_W,
  parameter int SETTLE_CYCLES = stp_pkg::SETTLE_CYC,
  parameter int RST_CYCLES = stp_pkg::RST_CYC
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  stp_if.tester link,
  input wire logic start_i,
  input wire logic [1:0] mode_i,
  output logic busy_o,
  input wire logic [WORD_W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [WORD_W-1:0] rx_data_o,
  output logic rx_valid_o
);
  localparam int BW = $clog2(WORD_W + 1);

  typedef enum {T_IDLE, T_SETTLE, T_PULSE} stp_tstate_t;

  // ****************************************************************
  // mode apply and reset pulse
  // ****************************************************************
  stp_tstate_t state_reg;
  logic [31:0] cnt_reg;
  logic [1:0] sel_reg;
  logic nrst_out_reg;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= T_IDLE;
      cnt_reg <= '0;
      sel_reg <= 2'h0;
      nrst_out_reg <= 1'b1;
      busy_o <= 1'b0;
    end else begin
      case (state_reg)
        T_IDLE: begin
          if (start_i) begin
            state_reg <= T_SETTLE;
            sel_reg <= mode_i; // R04 R12
            cnt_reg <= '0;
            busy_o <= 1'b1;
          end
        end
        T_SETTLE: begin
          cnt_reg <= cnt_reg + 32'h0000_0001;
          if (cnt_reg == 32'(SETTLE_CYCLES - 1)) begin
            state_reg <= T_PULSE; // R12
            cnt_reg <= '0;
            nrst_out_reg <= 1'b0;
          end
        end
        T_PULSE: begin
          cnt_reg <= cnt_reg + 32'h0000_0001;
          if (cnt_reg == 32'(RST_CYCLES - 1)) begin
            state_reg <= T_IDLE; // R06
            nrst_out_reg <= 1'b1;
            busy_o <= 1'b0;
          end
        end
        default: begin
          state_reg <= T_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // link domain: sample on rise, drive on fall
  // ****************************************************************
  logic [BW-1:0] rcnt_reg;
  logic [WORD_W-1:0] rsh_reg;
  logic [WORD_W-1:0] rx_word_reg;
  logic rx_tgl_reg;
  logic [BW-1:0] fcnt_reg;
  logic [WORD_W-1:0] tsh_reg;
  logic ld_tgl_reg;
  logic [WORD_W-1:0] tx_hold_reg;

  always_ff @(posedge link.link_clk or negedge nrst_i) begin
    if (!nrst_i) begin
      rcnt_reg <= '0;
      rsh_reg <= '0;
      rx_word_reg <= '0;
      rx_tgl_reg <= 1'b0;
    end else begin
      rsh_reg <= {rsh_reg[WORD_W-2:0], link.mob_data}; // R08
      if (rcnt_reg == BW'(WORD_W - 1)) begin
        rcnt_reg <= '0;
        rx_word_reg <= {rsh_reg[WORD_W-2:0], link.mob_data}; // R07
        rx_tgl_reg <= ~rx_tgl_reg;
      end else begin
        rcnt_reg <= rcnt_reg + BW'(1);
      end
    end
  end

  // the held word is stable here: it changes only after this load was seen
  always_ff @(negedge link.link_clk or negedge nrst_i) begin
    if (!nrst_i) begin
      fcnt_reg <= '0;
      tsh_reg <= '0;
      ld_tgl_reg <= 1'b0;
    end else if (fcnt_reg == '0) begin
      fcnt_reg <= BW'(1);
      tsh_reg <= tx_hold_reg; // R07 R08
      ld_tgl_reg <= ~ld_tgl_reg;
    end else begin
      fcnt_reg <= (fcnt_reg == BW'(WORD_W - 1)) ? '0 : fcnt_reg + BW'(1);
      tsh_reg <= {tsh_reg[WORD_W-2:0], 1'b0};
    end
  end

  // ****************************************************************
  // crossings back to the local clock
  // ****************************************************************
  logic [2:0] rx_sync_reg;
  logic [2:0] ld_sync_reg;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_sync_reg <= 3'h0;
      ld_sync_reg <= 3'h0;
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
      tx_hold_reg <= '0;
      tx_ready_o <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_tgl_reg};
      ld_sync_reg <= {ld_sync_reg[1:0], ld_tgl_reg};
      rx_valid_o <= rx_sync_reg[2] ^ rx_sync_reg[1];
      if (rx_sync_reg[2] ^ rx_sync_reg[1]) begin
        rx_data_o <= rx_word_reg;
      end
      if (tx_valid_i & tx_ready_o) begin
        tx_hold_reg <= tx_data_i;
        tx_ready_o <= 1'b0;
      end else if (ld_sync_reg[2] ^ ld_sync_reg[1]) begin
        tx_ready_o <= 1'b1;
      end
    end
  end

  assign link.tst_data = tsh_reg[WORD_W-1]; // R02
  assign link.sel = sel_reg; // R04 R10
  assign link.test_nrst = nrst_out_reg; // R06
endmodule : stp_tester

// *** stp_link_properties.sv ***
`timescale 1ns/10ps
module stp_link_properties #(
  parameter int HALF_CYC = 8,
  parameter int SETTLE_CYCLES = 50,
  parameter int RST_CYCLES = 20
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic link_clk,
  input wire logic mob_data,
  input wire logic tst_data,
  input wire logic [1:0] sel,
  input wire logic test_nrst
);
  int lo_cnt_reg;
  int hi_cnt_reg;
  int bit_cnt_reg;
  int sel_cnt_reg;
  int rst_cnt_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // ****************************************************************
  // helper counters
  // ****************************************************************
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) lo_cnt_reg <= 0;
    else lo_cnt_reg <= link_clk ? 0 : lo_cnt_reg + 1;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) hi_cnt_reg <= 0;
    else hi_cnt_reg <= link_clk ? hi_cnt_reg + 1 : 0;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) bit_cnt_reg <= 0;
    else if (!test_nrst) bit_cnt_reg <= 0;
    else if ($rose(link_clk)) bit_cnt_reg <= (bit_cnt_reg == 12) ? 0 : bit_cnt_reg + 1;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) sel_cnt_reg <= 0;
    else sel_cnt_reg <= $changed(sel) ? 0 : sel_cnt_reg + 1;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) rst_cnt_reg <= 0;
    else rst_cnt_reg <= test_nrst ? 0 : rst_cnt_reg + 1;
  end

  // ****************************************************************
  // link rules
  // ****************************************************************
  a_low_half_len: assert property (disable iff (!nrst_i || !test_nrst)
    $rose(link_clk) |-> lo_cnt_reg == HALF_CYC)
    else $error("link clock low half has wrong length");
  a_high_half_len: assert property (disable iff (!nrst_i || !test_nrst)
    $fell(link_clk) |-> hi_cnt_reg >= HALF_CYC)
    else $error("link clock high half too short");
  a_word_thirteen: assert property (
    hi_cnt_reg == HALF_CYC + 2 |-> bit_cnt_reg == 0)
    else $error("word did not carry thirteen bits");
  a_idle_in_reset: assert property (
    (!test_nrst)[*6] |-> link_clk)
    else $error("link clock runs during link reset");
  a_idle_normal: assert property (
    (sel == 2'h0)[*6] |-> link_clk)
    else $error("link clock runs in normal mode");
  a_mob_on_fall: assert property (disable iff (!nrst_i || !test_nrst)
    $changed(mob_data) |-> $fell(link_clk))
    else $error("mobile data changed off the falling edge");
  a_tst_stable_high: assert property (
    link_clk && $past(link_clk) |-> $stable(tst_data))
    else $error("tester data changed while clock high");
  a_settle_before: assert property (
    $fell(test_nrst) |-> sel_cnt_reg >= SETTLE_CYCLES - 1)
    else $error("reset applied before select settled");
  a_reset_width: assert property (
    $rose(test_nrst) |-> rst_cnt_reg >= RST_CYCLES)
    else $error("link reset pulse too short");
  a_sel_in_reset: assert property (
    !test_nrst |-> $stable(sel))
    else $error("select moved during link reset");
endmodule : stp_link_properties

// *** tb_speech_codec_test_serial_port.sv ***
`timescale 1ns/10ps
module tb_speech_codec_test_serial_port;
  localparam int HALF = 8;
  localparam int SETTLE = 50;
  localparam int RSTC = 20;
  logic clock_i = 1'b0;
  // starts high so the first reset is a real falling edge for every domain
  logic nrst_i = 1'b1;
  logic [12:0] dl_data_i = '0;
  logic dl_valid_i = 1'b0;
  logic dl_ready_o;
  logic [12:0] ul_data_o;
  logic ul_valid_o;
  logic ul_ready_i = 1'b0;
  logic frame_i = 1'b0;
  stp_pkg::stp_mode_t mode_o;
  logic codec_rst_o;
  logic codec_restart_o;
  logic start_i = 1'b0;
  logic [1:0] mode_i = 2'h0;
  logic busy_o;
  logic [12:0] tx_data_i = '0;
  logic tx_valid_i = 1'b0;
  logic tx_ready_o;
  logic [12:0] rx_data_o;
  logic rx_valid_o;
  int num_errors = 0;
  int comparisons = 0;
  stp_pkg::stp_mode_t exp_mode [4] = '{stp_pkg::STP_NORMAL, stp_pkg::STP_DOWNLINK,
    stp_pkg::STP_UPLINK, stp_pkg::STP_ACOUSTIC};

  stp_if stp_if_inst ();
  stp_mobile #(.HALF_CYC(HALF)) stp_mobile_inst (.clock_i(clock_i), .nrst_i(nrst_i),
    .link(stp_if_inst), .dl_data_i(dl_data_i), .dl_valid_i(dl_valid_i),
    .dl_ready_o(dl_ready_o), .ul_data_o(ul_data_o), .ul_valid_o(ul_valid_o),
    .ul_ready_i(ul_ready_i), .frame_i(frame_i), .mode_o(mode_o),
    .codec_rst_o(codec_rst_o), .codec_restart_o(codec_restart_o));
  stp_tester #(.SETTLE_CYCLES(SETTLE), .RST_CYCLES(RSTC)) stp_tester_inst (
    .clock_i(clock_i), .nrst_i(nrst_i), .link(stp_if_inst), .start_i(start_i),
    .mode_i(mode_i), .busy_o(busy_o), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
    .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o));
  stp_link_properties #(.HALF_CYC(HALF), .SETTLE_CYCLES(SETTLE), .RST_CYCLES(RSTC))
    stp_link_properties_inst (.clock_i(clock_i), .nrst_i(nrst_i),
    .link_clk(stp_if_inst.link_clk), .mob_data(stp_if_inst.mob_data),
    .tst_data(stp_if_inst.tst_data), .sel(stp_if_inst.sel),
    .test_nrst(stp_if_inst.test_nrst));

  initial begin
    forever #2 clock_i = ~clock_i;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic fail(input string msg);
    num_errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : fail

  function automatic bit bad(input bit b);
    comparisons++;
    return b;
  endfunction : bad

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic do_reset();
    @(posedge clock_i);
    nrst_i <= 1'b0;
    ul_ready_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
  endtask : do_reset

  task automatic pulse_frame();
    @(posedge clock_i);
    frame_i <= 1'b1;
    @(posedge clock_i);
    frame_i <= 1'b0;
  endtask : pulse_frame

  task automatic push(input bit to_tst, input logic [12:0] w, output bit ok);
    ok = 0;
    @(posedge clock_i);
    tx_data_i <= w;
    dl_data_i <= w;
    tx_valid_i <= to_tst;
    dl_valid_i <= !to_tst;
    for (int i = 0; i < 20; i++) begin
      @(posedge clock_i);
      ok = to_tst ? (tx_ready_o === 1'b1) : (dl_ready_o === 1'b1);
      if (ok) break;
    end
    tx_valid_i <= 1'b0;
    dl_valid_i <= 1'b0;
  endtask : push

  task automatic set_mode(input logic [1:0] m);
    bit seen_rst;
    bit seen_rs;
    seen_rst = 0;
    seen_rs = 0;
    @(posedge clock_i);
    start_i <= 1'b1;
    mode_i <= m;
    @(posedge clock_i);
    start_i <= 1'b0;
    repeat (SETTLE + RSTC + 20) begin
      @(posedge clock_i);
      if (codec_rst_o === 1'b1) seen_rst = 1;
      if (codec_restart_o === 1'b1) seen_rs = 1;
    end
    if (bad(seen_rst !== 1'b1)) fail("codec reset not seen");
    if (bad(seen_rs !== (m != 2'h0))) fail("restart pulse wrong");
    if (bad(mode_o !== exp_mode[m])) fail("mode decode wrong");
    if (bad(stp_if_inst.sel !== m || busy_o !== 1'b0)) fail("select lines wrong");
    if (bad(stp_if_inst.link_clk !== 1'b1)) fail("clock not idle");
  endtask : set_mode

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_modes();
    do_reset();
    for (int m = 0; m < 4; m++) set_mode(2'(m));
    $display("test modes done");
  endtask : test_modes

  task automatic xfer(input logic [1:0] m, input logic [12:0] dw, input logic [12:0] tw);
    bit ok;
    bit got_rx;
    bit got_ul;
    logic [12:0] rxw;
    logic [12:0] ulw;
    got_rx = 0;
    got_ul = 0;
    rxw = '0;
    ulw = '0;
    do_reset();
    set_mode(m);
    if (m[0]) push(1'b0, dw, ok);
    push(1'b1, tw, ok);
    if (bad(ok !== 1'b1)) fail("tester refused word");
    repeat (20) @(posedge clock_i);
    if (bad(stp_if_inst.link_clk !== 1'b1)) fail("clock before frame");
    pulse_frame();
    repeat (400) begin
      @(posedge clock_i);
      if (rx_valid_o === 1'b1) begin
        got_rx = 1;
        rxw = rx_data_o;
      end
      if (ul_valid_o === 1'b1) begin
        got_ul = 1;
        ulw = ul_data_o;
      end
    end
    if (bad(m[0] && (!got_rx || rxw !== dw))) fail("word to tester wrong");
    if (bad(got_ul != m[1] || (m[1] && ulw !== tw))) fail("word to mobile wrong");
    if (bad(m == 2'h2 && (!got_rx || rxw !== 13'h0000))) fail("uplink filler wrong");
    if (m[1]) begin
      @(posedge clock_i);
      ul_ready_i <= 1'b1;
      @(posedge clock_i);
      ul_ready_i <= 1'b0;
      @(posedge clock_i);
      if (bad(ul_valid_o !== 1'b0)) fail("uplink word not taken");
    end
    $display("test xfer mode %0d done", m);
  endtask : xfer

  task automatic fill_drain();
    bit ok;
    int n;
    logic [12:0] w;
    n = 0;
    do_reset();
    set_mode(2'h1);
    for (int i = 0; i < 18; i++) begin
      push(1'b0, 13'(i * 397 + 4096), ok);
      if (!ok) break;
      n++;
    end
    if (bad(n != stp_pkg::FIFO_DEPTH)) fail("fifo depth wrong");
    pulse_frame();
    for (int i = 0; i < n; i++) begin
      w = 'x;
      for (int k = 0; k < 400; k++) begin
        @(posedge clock_i);
        if (rx_valid_o === 1'b1) begin
          w = rx_data_o;
          break;
        end
      end
      if (bad(w !== 13'(i * 397 + 4096))) fail("drained word wrong");
    end
    repeat (40) @(posedge clock_i);
    if (bad(stp_if_inst.link_clk !== 1'b1 || dl_ready_o !== 1'b1)) fail("not idle");
    $display("test fill and drain done");
  endtask : fill_drain

  initial begin
    repeat (40000) @(posedge clock_i);
    fail("watchdog expired");
    report_and_stop();
  end

  initial begin
    test_modes();
    xfer(2'h1, 13'h1000, 13'h0001);
    xfer(2'h2, 13'h0000, 13'h0fff);
    xfer(2'h3, 13'h1555, 13'h0aaa);
    fill_drain();
    report_and_stop();
  end
endmodule : tb_speech_codec_test_serial_port
